// ---- core/hbsfc_core.sv ----
// h-bridge state decode and fault control
// What this block does
// R1: modulator drives complementary pairs per side
// R2: side a decodes pair, equal pair shuts down
// R3: side b decodes pair, equal pair shuts down
// R4: any fault shuts down, flag low; during reset only short circuit pulls flag low
// R5: faults drive low, short circuit releases hi-z
// R6: power-off forces both outputs hi-z
// R7: power-off releases all status pins
// R8: reset drives low, ignores pwm, clears latch
// R9: power-off overrides reset
// R10: short circuit latches hi-z until reset; power-off also clears latch
// R11: other faults self-clear when condition ends
// R12: stalled pwm counts as illegal input
// R13: flag low gives fault code
// R14: flag high gives warning or normal code
// R15: status pins open-drain, wire-or capable
// R16: controller holds reset low at power-up
// R17: reset clears every held fault
// R18: toggle timeout counter detects stalled pwm
`timescale 1ns/1ps
`default_nettype none
module hbsfc_core #(
  parameter int TIMEOUT = hbsfc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // pins from the modulator and system
  input wire logic pwm_side_a_pos_i,
  input wire logic pwm_side_a_neg_i,
  input wire logic pwm_side_b_pos_i,
  input wire logic pwm_side_b_neg_i,
  input wire logic power_off_n_i,
  input wire logic bridge_reset_n_i,
  // analog sense inputs
  input wire logic overcurrent_i,
  input wire logic overtemp_i,
  input wire logic temp_warn_i,
  input wire logic undervolt_i,
  // bridge outputs: level and drive enable
  output logic bridge_out_pos_o,
  output logic bridge_out_pos_oe_o,
  output logic bridge_out_neg_o,
  output logic bridge_out_neg_oe_o,
  // open-drain status pins
  output logic shutdown_n_o,
  output logic shutdown_n_oe_o,
  output logic fault_code_bit0_o,
  output logic fault_code_bit0_oe_o,
  output logic fault_code_bit1_o,
  output logic fault_code_bit1_oe_o
);
  import hbsfc_pkg::*;
  // two-stage synchronisers for every input but mclk_i and resetn_i; bridge reset pin included
  logic [9:0] meta_r;
  logic [9:0] sync_r;
  always_ff @(posedge mclk_i) begin
    meta_r <= {pwm_side_a_pos_i, pwm_side_a_neg_i, pwm_side_b_pos_i,
               pwm_side_b_neg_i, power_off_n_i, bridge_reset_n_i,
               overcurrent_i, overtemp_i, temp_warn_i, undervolt_i};
    sync_r <= meta_r;
  end
  logic ap, an, bp, bn, pon, rstn, oc, ot, tw, uv;
  assign {ap, an, bp, bn, pon, rstn, oc, ot, tw, uv} = sync_r;

  function automatic logic pair_illegal(input logic p, input logic n);
    return ~(p ^ n);
  endfunction : pair_illegal

  logic stall_a;
  logic stall_b;
  logic det_clear;
  assign det_clear = !pon || !rstn;
  hbsfc_activity #(.TIMEOUT(TIMEOUT), .CNT_W(TIMER_W)) u_act_a (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .pos_i(ap), .neg_i(an),
    .clear_i(det_clear), .stalled_o(stall_a));
  hbsfc_activity #(.TIMEOUT(TIMEOUT), .CNT_W(TIMER_W)) u_act_b (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .pos_i(bp), .neg_i(bn),
    .clear_i(det_clear), .stalled_o(stall_b));

  logic illegal;
  assign illegal = pair_illegal(ap, an) | pair_illegal(bp, bn) // R2 R3
                   | stall_a | stall_b; // R12

  // short-circuit latch; set wins over a simultaneous clear
  logic short_r;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i)
      short_r <= 1'b0;
    else if (pon && oc)
      short_r <= 1'b1; // R10
    else if (!pon || !rstn)
      short_r <= 1'b0; // R8 R17
  end

  hbsfc_mode_t mode;
  always_comb begin
    if (!pon)
      mode = HBSFC_OFF; // R9
    else if (short_r || oc)
      mode = HBSFC_FAULT;
    else if (!rstn)
      mode = HBSFC_RESET;
    else if (ot || uv || illegal)
      mode = HBSFC_FAULT; // R4 R11
    else
      mode = HBSFC_RUN;
  end

  logic [1:0] code;
  always_comb begin
    if (short_r || oc)
      code = CODE_SHORT;
    else if (uv)
      code = CODE_UNDERVOLT;
    else if (ot)
      code = CODE_OVERTEMP;
    else
      code = CODE_ILLEGAL;
  end

  // bridge outputs, registered
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      bridge_out_pos_o <= 1'b0;
      bridge_out_neg_o <= 1'b0;
      bridge_out_pos_oe_o <= 1'b0;
      bridge_out_neg_oe_o <= 1'b0;
    end else begin
      unique case (mode)
        HBSFC_OFF: begin
          bridge_out_pos_oe_o <= 1'b0; // R6
          bridge_out_neg_oe_o <= 1'b0;
          bridge_out_pos_o <= 1'b0;
          bridge_out_neg_o <= 1'b0;
        end
        HBSFC_RESET: begin
          bridge_out_pos_oe_o <= 1'b1; // R8
          bridge_out_neg_oe_o <= 1'b1;
          bridge_out_pos_o <= 1'b0;
          bridge_out_neg_o <= 1'b0;
        end
        HBSFC_FAULT: begin
          bridge_out_pos_oe_o <= !(short_r || oc); // R5 R10
          bridge_out_neg_oe_o <= !(short_r || oc);
          bridge_out_pos_o <= 1'b0;
          bridge_out_neg_o <= 1'b0;
        end
        HBSFC_RUN: begin
          bridge_out_pos_oe_o <= 1'b1;
          bridge_out_neg_oe_o <= 1'b1;
          bridge_out_pos_o <= ap; // R2
          bridge_out_neg_o <= bp; // R3
        end
      endcase
    end
  end

  // status pins: only ever pull low; level output stays 0
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      shutdown_n_oe_o <= 1'b0;
      fault_code_bit0_oe_o <= 1'b0;
      fault_code_bit1_oe_o <= 1'b0;
    end else if (mode == HBSFC_OFF) begin
      shutdown_n_oe_o <= 1'b0; // R7
      fault_code_bit0_oe_o <= 1'b0;
      fault_code_bit1_oe_o <= 1'b0;
    end else if (mode == HBSFC_FAULT) begin
      shutdown_n_oe_o <= 1'b1; // R4 R13
      fault_code_bit0_oe_o <= !code[0];
      fault_code_bit1_oe_o <= !code[1];
    end else begin
      shutdown_n_oe_o <= 1'b0; // R14
      fault_code_bit0_oe_o <= (mode == HBSFC_RUN) && tw;
      fault_code_bit1_oe_o <= 1'b0;
    end
  end
  assign shutdown_n_o = 1'b0; // R15
  assign fault_code_bit0_o = 1'b0;
  assign fault_code_bit1_o = 1'b0;

  // assertions
  default clocking cb_chk @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_OFF_HIZ: assert property ( // R6
    !pon |=> !bridge_out_pos_oe_o && !bridge_out_neg_oe_o)
    else $error("outputs driven while powered off");
  AST_OFF_RELEASE: assert property ( // R7
    !pon |=> !shutdown_n_oe_o && !fault_code_bit0_oe_o
    && !fault_code_bit1_oe_o)
    else $error("status pulled while powered off");
  AST_RESET_LOW: assert property ( // R8
    pon && !rstn && !short_r && !oc |=> bridge_out_pos_oe_o
    && !bridge_out_pos_o && bridge_out_neg_oe_o && !bridge_out_neg_o)
    else $error("reset did not drive low");
  AST_SHORT_HOLD: assert property ( // R10
    short_r && pon && rstn |=> short_r)
    else $error("short latch released without reset");
  AST_SHORT_HIZ: assert property ( // R5
    short_r && pon |=> !bridge_out_pos_oe_o && !bridge_out_neg_oe_o
    && shutdown_n_oe_o && fault_code_bit1_oe_o && !fault_code_bit0_oe_o)
    else $error("short circuit not hi-z with code 01");
  AST_ILLEGAL: assert property ( // R2
    pon && rstn && !short_r && !oc && ap == an |=> shutdown_n_oe_o
    && !bridge_out_pos_o && bridge_out_pos_oe_o)
    else $error("equal pair a not shut down");
  AST_ILLEGAL_B: assert property ( // R3
    pon && rstn && !short_r && !oc && bp == bn |=> shutdown_n_oe_o
    && !bridge_out_neg_o && bridge_out_neg_oe_o)
    else $error("equal pair b not shut down");
  AST_DECODE: assert property ( // R2 R3
    mode == HBSFC_RUN |=> bridge_out_pos_o == $past(ap)
    && bridge_out_neg_o == $past(bp) && !shutdown_n_oe_o)
    else $error("normal decode wrong");
  // no fault cause left: outputs must decode again at the next edge
  AST_RECOVER: assert property ( // R11
    pon && rstn && !short_r && !oc && !ot && !uv && !illegal
    |=> !shutdown_n_oe_o && bridge_out_pos_oe_o
    && bridge_out_pos_o == $past(ap))
    else $error("self-clearing fault did not release");
  AST_UV_CODE: assert property ( // R13
    pon && uv && !short_r && !oc && rstn |=> shutdown_n_oe_o
    && !fault_code_bit0_oe_o && !fault_code_bit1_oe_o)
    else $error("undervoltage code wrong");
  COV_RUN: cover property (@(posedge mclk_i) mode == HBSFC_RUN [*3]);
  COV_SHORT: cover property (@(posedge mclk_i) short_r ##1 !rstn);
  COV_STALL: cover property (@(posedge mclk_i) stall_a);
  COV_OFF: cover property (@(posedge mclk_i) !pon && !rstn);
endmodule : hbsfc_core
`default_nettype wire

// ---- inc/hbsfc_pkg.sv ----
// constants shared by the h-bridge state and fault control block
`default_nettype none
package hbsfc_pkg;
  // error code values (bit1, bit0)
  localparam logic [1:0] CODE_ILLEGAL = 2'h0;
  localparam logic [1:0] CODE_SHORT = 2'h1;
  localparam logic [1:0] CODE_OVERTEMP = 2'h2;
  localparam logic [1:0] CODE_UNDERVOLT = 2'h3;
  localparam logic [1:0] CODE_WARN = 2'h2;
  localparam logic [1:0] CODE_NORMAL = 2'h3;
  // activity timeout on the pwm inputs
  localparam int CLK_HZ = 20000000;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000000) * TIMEOUT_US;
  localparam int TIMER_W = 12;
  typedef enum logic [1:0] {
    HBSFC_OFF = 2'h0,
    HBSFC_RESET = 2'h1,
    HBSFC_RUN = 2'h3,
    HBSFC_FAULT = 2'h2
  } hbsfc_mode_t;
endpackage : hbsfc_pkg
`default_nettype wire

// ---- core/hbsfc_activity.sv ----
// loss-of-toggle detector for one pwm input pair
`timescale 1ns/1ps
`default_nettype none
module hbsfc_activity #(
  parameter int TIMEOUT = hbsfc_pkg::TIMEOUT_CYC,
  parameter int CNT_W = hbsfc_pkg::TIMER_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // synchronised pair, clear request
  input wire logic pos_i,
  input wire logic neg_i,
  input wire logic clear_i,
  // result
  output logic stalled_o
);
  import hbsfc_pkg::*;
  // refuse a timeout that the counter cannot reach
  if (TIMEOUT < 1 || TIMEOUT >= (1 << CNT_W)) begin : g_bad_timeout
    $error("hbsfc_activity: TIMEOUT does not fit counter");
  end
  logic pos_d_r;
  logic neg_d_r;
  logic [CNT_W-1:0] cnt_r;
  logic edge_seen;
  assign edge_seen = (pos_i ^ pos_d_r) | (neg_i ^ neg_d_r);
  always_ff @(posedge mclk_i) begin
    pos_d_r <= pos_i;
    neg_d_r <= neg_i;
  end
  // counter restarts on any toggle of either line
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || clear_i || edge_seen) begin // R18
      cnt_r <= '0;
      stalled_o <= 1'b0;
    end else if (cnt_r == CNT_W'(TIMEOUT - 1)) begin
      stalled_o <= 1'b1; // R12
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end
endmodule : hbsfc_activity
`default_nettype wire

// ---- tb/hbsfc_modulator.sv ----
// complementary pwm modulator model driving both half-bridge pairs
`timescale 1ns/1ps
`default_nettype none
module hbsfc_modulator (
  // clock
  input wire logic mclk_i,
  // requested levels and illegal-state injection
  input wire logic val_a_i,
  input wire logic val_b_i,
  input wire logic equal_i,
  input wire logic equal_b_i,
  // pwm pairs
  output logic a_pos_o,
  output logic a_neg_o,
  output logic b_pos_o,
  output logic b_neg_o
);
  // equal pairs only when a scenario asks for an illegal state
  always_ff @(posedge mclk_i) begin
    a_pos_o <= val_a_i;
    a_neg_o <= equal_i ? val_a_i : ~val_a_i;
    b_pos_o <= val_b_i;
    b_neg_o <= (equal_i || equal_b_i) ? val_b_i : ~val_b_i;
  end
endmodule : hbsfc_modulator
`default_nettype wire

// ---- tb/tb_hbsfc_core.sv ----
// self-checking bench for the h-bridge state and fault control core
`timescale 1ns/1ps
`default_nettype none
module tb_hbsfc_core;
  import hbsfc_pkg::*;
  localparam int TMO = 16;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic a = 1'b0, b = 1'b0, eq = 1'b0, pwr = 1'b1, rst = 1'b0;
  logic oc = 1'b0, ot = 1'b0, tw = 1'b0, uv = 1'b0, lat = 1'b0;
  logic eqb = 1'b0;
  logic ap, an, bp, bn, po, poe, no, noe;
  logic sd, sdoe, c0, c0oe, c1, c1oe;
  logic [8:0] corners [12];
  int bad_count = 0;
  int checked = 0;
  always #25 mclk_i = ~mclk_i;
  hbsfc_modulator pwm (.mclk_i(mclk_i), .val_a_i(a), .val_b_i(b),
    .equal_i(eq), .equal_b_i(eqb), .a_pos_o(ap), .a_neg_o(an),
    .b_pos_o(bp), .b_neg_o(bn));
  hbsfc_core #(.TIMEOUT(TMO)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .pwm_side_a_pos_i(ap), .pwm_side_a_neg_i(an), .pwm_side_b_pos_i(bp),
    .pwm_side_b_neg_i(bn), .power_off_n_i(pwr), .bridge_reset_n_i(rst),
    .overcurrent_i(oc), .overtemp_i(ot), .temp_warn_i(tw),
    .undervolt_i(uv), .bridge_out_pos_o(po), .bridge_out_pos_oe_o(poe),
    .bridge_out_neg_o(no), .bridge_out_neg_oe_o(noe),
    .shutdown_n_o(sd), .shutdown_n_oe_o(sdoe), .fault_code_bit0_o(c0),
    .fault_code_bit0_oe_o(c0oe), .fault_code_bit1_o(c1),
    .fault_code_bit1_oe_o(c1oe));
  // {pos oe, pos, neg oe, neg, pin levels sd c1 c0, open-drain data}
  function automatic logic [9:0] exp_f(input logic st);
    if (!pwr) return {4'h0, 3'h7, 3'h0};
    if (lat) return {4'h0, 1'b0, CODE_SHORT, 3'h0};
    if (!rst) return {4'hA, 3'h7, 3'h0};
    if (uv) return {4'hA, 1'b0, CODE_UNDERVOLT, 3'h0};
    if (ot) return {4'hA, 1'b0, CODE_OVERTEMP, 3'h0};
    if (eq || eqb || st) return {4'hA, 1'b0, CODE_ILLEGAL, 3'h0};
    return {1'b1, a, 1'b1, b, 1'b1, tw ? CODE_WARN : CODE_NORMAL, 3'h0};
  endfunction : exp_f
  task automatic step(input logic st, input int w);
    logic [9:0] e;
    logic [9:0] o;
    lat = pwr & (oc | (lat & rst));
    repeat (w) @(posedge mclk_i);
    #1;
    e = exp_f(st);
    // released open-drain pins read high through the pullup
    o = {poe, poe & po, noe, noe & no, ~sdoe, ~c1oe, ~c0oe, sd, c1, c0};
    checked++;
    if (o !== e) begin
      bad_count++;
      $display("CHECK FAILED outputs expected %h seen %h", e, o);
    end
  endtask : step
  // a toggle before each setting keeps the activity timer from expiring
  task automatic go(input logic [8:0] v);
    @(posedge mclk_i);
    #5;
    a = ~v[8];
    b = ~v[7];
    @(posedge mclk_i);
    #5;
    {a, b, eq, pwr, rst, oc, ot, tw, uv} = v;
    step(1'b0, 7);
  endtask : go
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (100000) @(posedge mclk_i);
    bad_count++;
    print_verdict();
  end
  initial begin
    logic [8:0] v;
    logic [31:0] r;
    r = $urandom(32'h5eb5);
    // {a, b, equal, power, bridge reset, oc, ot, warn, uv}
    corners = '{9'b100110000, 9'b010110000, 9'b111110000, 9'b001110000,
      9'b100110010, 9'b100110100, 9'b100110001, 9'b100111000,
      9'b100110000, 9'b100100000, 9'b100010000, 9'b010110000};
    repeat (10) @(posedge mclk_i);
    #5;
    resetn_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    foreach (corners[i]) go(corners[i]);
    $display("test corners done");
    go(9'b010110000);
    step(1'b1, 40);
    go(9'b100110000);
    // side b alone made illegal, side a stays legal
    @(posedge mclk_i);
    #5;
    eqb = 1'b1;
    go(9'b010110000);
    @(posedge mclk_i);
    #5;
    eqb = 1'b0;
    go(9'b100110000);
    $display("test stall done");
    repeat (300) begin
      r = $urandom;
      v = {r[0], r[1], &r[4:2], |r[7:5], |r[10:8], &r[13:11], &r[17:15],
        r[18], &r[21:19]};
      if (!v[5]) v[3] = 1'b0;
      go(v);
    end
    $display("test random done");
    print_verdict();
  end
endmodule : tb_hbsfc_core
`default_nettype wire
